/* File: rtl/gst_timer.sv */
// Purpose: Gated sixteen-bit timer with AHB-Lite register access.
// Assumes: sevt_in is a one-cycle pulse on core_clk_in; pins are asynchronous.
// Notes: Reads take one wait state; writes take none.
`timescale 1ns/1ns
module gst_timer import gst_pkg::*; (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic hsel_in,
  input wire logic [GST_ADDR_W-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  input wire logic external_clock_pin_in,
  input wire logic timer_osc_clk_in,
  input wire logic device_clock_from_timer_osc_in,
  input wire logic [3:0] gate_src_in,
  input wire logic sevt_in,
  output logic oscillator_enable_out,
  output logic gate_value_out,
  output logic irq_out
);

  // ==========================================================================
  // Pin synchronisers
  logic [6:0] pin_s;

  gst_sync2 #(.W(7)) u_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in({gate_src_in, device_clock_from_timer_osc_in, timer_osc_clk_in, external_clock_pin_in}),
    .sync_out(pin_s)
  );

  // ==========================================================================
  // Bus phase tracking
  logic dp_act_ff, dp_wr_ff, dp_ok_ff, rd_done_ff;
  logic nxt_dp_act, nxt_dp_wr, nxt_dp_ok, nxt_rd_done;
  logic [11:0] dp_idx_ff, nxt_dp_idx;
  logic [7:0] rdata_ff, nxt_rdata, wd, rmux;
  logic ap_valid, rd_cycle, wr_cycle;

  logic [7:0] ctl_ff;
  logic [15:0] count_ff;
  logic [7:0] hbuf_ff;
  logic [6:0] gcfg_ff;
  logic [1:0] st_ff;
  logic [1:0] mask_ff;
  gst_sp_e sp_ff;
  logic gval;

  assign ap_valid = hsel_in && hready_in && htrans_in[1];
  assign rd_cycle = dp_act_ff && !dp_wr_ff && !rd_done_ff;
  assign wr_cycle = dp_act_ff && dp_wr_ff && dp_ok_ff;
  assign wd = hwdata_in[7:0];
  assign hreadyout_out = !rd_cycle;
  assign hresp_out = 1'b0;
  assign hrdata_out = {24'h00_0000, rdata_ff};

  always_comb begin
    rmux = 8'h00;
    if (dp_ok_ff) begin
      case (dp_idx_ff)
        GST_IDX_CONTROL: rmux = ctl_ff;
        GST_IDX_COUNT_LO: rmux = count_ff[7:0];
        GST_IDX_COUNT_HI: rmux = ctl_ff[GST_CTL_WIDE] ? hbuf_ff : count_ff[15:8];
        GST_IDX_GATE: rmux = {gcfg_ff[6:3], sp_ff != GST_SP_IDLE, gval, gcfg_ff[1:0]};
        GST_IDX_CLKCTL: rmux = 8'(pin_s[2]) << GST_CC_OSC_RUN;
        GST_IDX_IRQ_ST: rmux = {6'h00, st_ff};
        GST_IDX_IRQ_MASK: rmux = {6'h00, mask_ff};
        default: rmux = 8'h00;
      endcase
    end
  end

  always_comb begin
    nxt_dp_act = dp_act_ff;
    nxt_dp_wr = dp_wr_ff;
    nxt_dp_ok = dp_ok_ff;
    nxt_dp_idx = dp_idx_ff;
    nxt_rd_done = rd_done_ff;
    nxt_rdata = rdata_ff;
    if (rd_cycle) begin
      nxt_rdata = rmux;
      nxt_rd_done = 1'b1;
    end else begin
      nxt_dp_act = ap_valid;
      nxt_dp_wr = hwrite_in;
      nxt_dp_idx = haddr_in[13:2];
      nxt_dp_ok = (haddr_in[15:14] == 2'h0) && (haddr_in[1:0] == 2'h0);
      nxt_rd_done = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      dp_act_ff <= 1'b0;
      dp_wr_ff <= 1'b0;
      dp_ok_ff <= 1'b0;
      dp_idx_ff <= 12'h000;
      rd_done_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      dp_act_ff <= nxt_dp_act;
      dp_wr_ff <= nxt_dp_wr;
      dp_ok_ff <= nxt_dp_ok;
      dp_idx_ff <= nxt_dp_idx;
      rd_done_ff <= nxt_rd_done;
      rdata_ff <= nxt_rdata;
    end
  end

  logic wr_ctl, wr_lo, wr_hi, wr_gate, wr_st, wr_mask, rd_lo, wr_cnt;

  assign wr_ctl = wr_cycle && dp_idx_ff == GST_IDX_CONTROL;
  assign wr_lo = wr_cycle && dp_idx_ff == GST_IDX_COUNT_LO;
  assign wr_hi = wr_cycle && dp_idx_ff == GST_IDX_COUNT_HI;
  assign wr_gate = wr_cycle && dp_idx_ff == GST_IDX_GATE;
  assign wr_st = wr_cycle && dp_idx_ff == GST_IDX_IRQ_ST;
  assign wr_mask = wr_cycle && dp_idx_ff == GST_IDX_IRQ_MASK;
  assign rd_lo = rd_cycle && dp_ok_ff && dp_idx_ff == GST_IDX_COUNT_LO;
  assign wr_cnt = wr_lo || (wr_hi && !ctl_ff[GST_CTL_WIDE]);

  // ==========================================================================
  // Control register
  logic [7:0] nxt_ctl;
  gst_src_e src;

  always_comb begin
    nxt_ctl = wr_ctl ? wd : ctl_ff;
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ctl_ff <= GST_CONTROL_RST;
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  assign src = gst_src_e'(ctl_ff[GST_CTL_SRC_LO +: 2]);
  assign oscillator_enable_out = ctl_ff[GST_CTL_OSC_EN];

  // ==========================================================================
  // Clock source selection
  logic [1:0] qdiv_ff, nxt_qdiv;
  logic ext_d_ff, pend_ff, nxt_ext_d, nxt_pend, qtick, ext_s, ext_rise, ext_tick, src_tick;

  assign qtick = qdiv_ff == GST_INSTR_LAST;
  assign ext_s = ctl_ff[GST_CTL_OSC_EN] ? pin_s[1] : pin_s[0];
  assign ext_rise = ext_s && !ext_d_ff;

  always_comb begin
    nxt_qdiv = qdiv_ff + 2'h1;
    nxt_ext_d = ext_s;
    nxt_pend = (pend_ff || ext_rise) && !qtick;
    // Synchronised mode holds an edge until the instruction clock phase
    if (ctl_ff[GST_CTL_SYNC_BYP]) begin
      ext_tick = ext_rise;
    end else begin
      ext_tick = (pend_ff || ext_rise) && qtick;
    end
    case (src)
      GST_SRC_INSTR: src_tick = qtick;
      GST_SRC_SYS: src_tick = 1'b1;
      GST_SRC_EXT: src_tick = ext_tick;
      default: src_tick = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      qdiv_ff <= 2'h0;
      ext_d_ff <= 1'b0;
      pend_ff <= 1'b0;
    end else begin
      qdiv_ff <= nxt_qdiv;
      ext_d_ff <= nxt_ext_d;
      pend_ff <= nxt_pend;
    end
  end

  // ==========================================================================
  // Gate
  logic [6:0] nxt_gcfg;
  gst_sp_e nxt_sp;
  logic act_d_ff, tog_ff, lvl_d_ff, nxt_act_d, nxt_tog, nxt_lvl_d, g_sel, g_act, g_lvl, done_ev;

  assign g_sel = pin_s[3 + gcfg_ff[GST_GC_SRC_LO +: 2]];
  assign g_act = gcfg_ff[GST_GC_POL - 1] ? g_sel : !g_sel;
  assign g_lvl = gcfg_ff[GST_GC_TM - 1] ? tog_ff : g_act;
  assign gval = gcfg_ff[GST_GC_SPM - 1] ? (sp_ff == GST_SP_OPEN) : g_lvl;
  assign gate_value_out = gval;

  always_comb begin
    nxt_gcfg = gcfg_ff;
    if (wr_gate) begin
      nxt_gcfg = {wd[7:4], 1'b0, wd[1:0]};
    end
    nxt_act_d = g_act;
    nxt_lvl_d = g_lvl;
    nxt_tog = gcfg_ff[GST_GC_TM - 1] ? (tog_ff ^ (g_act && !act_d_ff)) : 1'b0;
    nxt_sp = sp_ff;
    done_ev = 1'b0;
    case (sp_ff)
      GST_SP_IDLE: begin
        if (wr_gate && wd[GST_GC_GO]) begin
          nxt_sp = GST_SP_ARMED;
        end
      end
      GST_SP_ARMED: begin
        if (wr_gate && !wd[GST_GC_GO]) begin
          nxt_sp = GST_SP_IDLE;
        end else if (g_lvl && !lvl_d_ff) begin
          nxt_sp = GST_SP_OPEN;
        end
      end
      GST_SP_OPEN: begin
        if (!g_lvl && lvl_d_ff) begin
          nxt_sp = GST_SP_IDLE;
          done_ev = 1'b1;
        end else if (wr_gate && !wd[GST_GC_GO]) begin
          nxt_sp = GST_SP_IDLE;
        end
      end
      default: nxt_sp = GST_SP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      gcfg_ff <= GST_GATE_RST[6:0];
      act_d_ff <= 1'b1; // Reset polarity makes an idle low gate active
      tog_ff <= 1'b0;
      lvl_d_ff <= 1'b1;
      sp_ff <= GST_SP_IDLE;
    end else begin
      gcfg_ff <= nxt_gcfg;
      act_d_ff <= nxt_act_d;
      tog_ff <= nxt_tog;
      lvl_d_ff <= nxt_lvl_d;
      sp_ff <= nxt_sp;
    end
  end

  // ==========================================================================
  // Counter
  logic cnt_en;
  logic inc;
  logic ovf_ev;
  logic [15:0] nxt_count;
  logic [7:0] nxt_hbuf;

  assign cnt_en = ctl_ff[GST_CTL_RUN] && (!gcfg_ff[GST_GC_EN - 1] || gval);
  assign ovf_ev = inc && count_ff == GST_COUNT_MAX && !sevt_in && !wr_cnt;

  gst_prescale #(.W(3)) u_psc (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .tick_in(src_tick && cnt_en),
    .sel_in(ctl_ff[GST_CTL_PSC_LO +: 2]),
    .clear_in(wr_cnt || sevt_in),
    .tick_out(inc)
  );

  always_comb begin
    nxt_count = count_ff;
    nxt_hbuf = hbuf_ff;
    if (inc) begin
      nxt_count = count_ff + 16'h0001;
    end
    if (wr_lo) begin
      nxt_count = ctl_ff[GST_CTL_WIDE] ? {hbuf_ff, wd} : {count_ff[15:8], wd};
    end
    if (wr_hi) begin
      if (ctl_ff[GST_CTL_WIDE]) begin
        nxt_hbuf = wd;
      end else begin
        nxt_count = {wd, count_ff[7:0]};
      end
    end
    if (rd_lo && ctl_ff[GST_CTL_WIDE]) begin
      nxt_hbuf = count_ff[15:8];
    end
    if (sevt_in) begin
      nxt_count = GST_COUNT_RST;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      count_ff <= GST_COUNT_RST;
      hbuf_ff <= 8'h00;
    end else begin
      count_ff <= nxt_count;
      hbuf_ff <= nxt_hbuf;
    end
  end

  // ==========================================================================
  // Interrupts
  logic [1:0] nxt_st;
  logic [1:0] nxt_mask;
  logic [1:0] ev;

  assign ev = {done_ev, ovf_ev};
  assign irq_out = |(st_ff & mask_ff);

  always_comb begin
    nxt_st = st_ff;
    if (wr_st) begin
      nxt_st = st_ff & ~wd[1:0];
    end
    nxt_st = nxt_st | ev;
    nxt_mask = wr_mask ? wd[1:0] : mask_ff;
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st_ff <= GST_IRQ_RST;
      mask_ff <= GST_IRQ_RST;
    end else begin
      st_ff <= nxt_st;
      mask_ff <= nxt_mask;
    end
  end

  // ==========================================================================
  // Checks
  halt_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (!ctl_ff[GST_CTL_RUN] && !sevt_in && !wr_lo && !wr_hi) |=> $stable(count_ff))
    else $error("count moved while halted");
  sevt_clear_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    sevt_in |=> (count_ff == 16'h0000)) else $error("special event did not clear count");
  ovf_flag_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (inc && count_ff == 16'hffff && !sevt_in && !wr_cnt) |=> (st_ff[0] && count_ff == 16'h0000))
    else $error("rollover did not set overflow flag");
  ovf_irq_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (ovf_ev && mask_ff[0] && !wr_mask) |=> irq_out) else $error("masked-in overflow gave no interrupt");
  instr_src_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (src == GST_SRC_INSTR && inc) |-> (qdiv_ff == 2'h3)) else $error("instruction source counted off phase");
  sync_ignore_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (src == GST_SRC_SYS && cnt_en && ctl_ff[GST_CTL_PSC_LO +: 2] == 2'h0) |-> inc) else $error("system clock tick lost");
  wide_latch_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (rd_lo && ctl_ff[GST_CTL_WIDE] && !wr_hi) |=> (hbuf_ff == $past(count_ff[15:8])))
    else $error("wide read did not latch high byte");
  pulse_done_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (sp_ff == GST_SP_OPEN && !g_lvl && lvl_d_ff) |=> (sp_ff == GST_SP_IDLE && st_ff[1]))
    else $error("single pulse did not end on falling gate");
  ctl_reset_a: assert property (@(posedge core_clk_in)
    $rose(rst_n_in) |-> (ctl_ff == 8'h00 && !oscillator_enable_out)) else $error("control not zero after reset");
  ext_sync_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (src == GST_SRC_EXT && !ctl_ff[GST_CTL_SYNC_BYP] && src_tick) |-> qtick)
    else $error("synchronised external tick off instruction phase");

endmodule

/* File: rtl/gst_pkg.sv */
// Purpose: Shared constants for the gated sixteen-bit timer.
// Assumes: AHB-Lite word registers; byte address is four times the register index.
// Notes: Only the low byte of each register word is implemented.

package gst_pkg;

  // ==========================================================================
  // Register indices
  localparam int unsigned GST_ADDR_W = 16;
  localparam logic [11:0] GST_IDX_CONTROL = 12'hfcd;
  localparam logic [11:0] GST_IDX_COUNT_LO = 12'hfce;
  localparam logic [11:0] GST_IDX_COUNT_HI = 12'hfcf;
  localparam logic [11:0] GST_IDX_GATE = 12'hfd0;
  localparam logic [11:0] GST_IDX_CLKCTL = 12'hfd1;
  localparam logic [11:0] GST_IDX_IRQ_ST = 12'hfd2;
  localparam logic [11:0] GST_IDX_IRQ_MASK = 12'hfd3;

  // ==========================================================================
  // Field positions
  localparam int unsigned GST_CTL_RUN = 0;
  localparam int unsigned GST_CTL_WIDE = 1;
  localparam int unsigned GST_CTL_SYNC_BYP = 2;
  localparam int unsigned GST_CTL_OSC_EN = 3;
  localparam int unsigned GST_CTL_PSC_LO = 4;
  localparam int unsigned GST_CTL_SRC_LO = 6;
  localparam int unsigned GST_GC_SRC_LO = 0;
  localparam int unsigned GST_GC_VAL = 2;
  localparam int unsigned GST_GC_GO = 3;
  localparam int unsigned GST_GC_SPM = 4;
  localparam int unsigned GST_GC_TM = 5;
  localparam int unsigned GST_GC_POL = 6;
  localparam int unsigned GST_GC_EN = 7;
  localparam int unsigned GST_CC_OSC_RUN = 4;
  localparam int unsigned GST_ST_OVF = 0;
  localparam int unsigned GST_ST_DONE = 1;

  // ==========================================================================
  // Reset values and counts
  localparam logic [7:0] GST_CONTROL_RST = 8'h00;
  localparam logic [7:0] GST_GATE_RST = 8'h00;
  localparam logic [1:0] GST_IRQ_RST = 2'h0;
  localparam logic [15:0] GST_COUNT_RST = 16'h0000;
  localparam logic [15:0] GST_COUNT_MAX = 16'hffff;
  localparam logic [1:0] GST_INSTR_LAST = 2'h3;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    GST_SRC_INSTR = 2'h0,
    GST_SRC_SYS = 2'h1,
    GST_SRC_EXT = 2'h2,
    GST_SRC_RSVD = 2'h3
  } gst_src_e;

  typedef enum logic [2:0] {
    GST_SP_IDLE = 3'h1,
    GST_SP_ARMED = 3'h2,
    GST_SP_OPEN = 3'h4
  } gst_sp_e;

endpackage

/* File: rtl/gst_sync2.sv */
// Purpose: Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes: Each bit is independent; no bus coherence.
// Notes: Only the second stage may be read outside.
`timescale 1ns/1ns
module gst_sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

/* File: rtl/gst_prescale.sv */
// Purpose: Divides a tick enable by 1, 2, 4 or 8.
// Assumes: tick_in is a one-cycle enable on core_clk_in.
// Notes: clear_in restarts the division.
`timescale 1ns/1ns
module gst_prescale #(
  parameter int unsigned W = 3
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire logic [1:0] sel_in,
  input wire logic clear_in,
  output logic tick_out
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic [W-1:0] mask;

  // ==========================================================================
  // Divide
  always_comb begin
    mask = W'((1 << sel_in) - 1);
    tick_out = tick_in && ((cnt_ff & mask) == mask);
    nxt_cnt = cnt_ff;
    if (clear_in) begin
      nxt_cnt = '0;
    end else if (tick_out) begin
      nxt_cnt = '0;
    end else if (tick_in) begin
      nxt_cnt = cnt_ff + W'(1);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // ==========================================================================
  // Checks
  div_one_pass_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (sel_in == 2'h0) |-> (tick_out == tick_in)) else $error("divide by one must pass every tick");
  div_eight_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (tick_out && sel_in == 2'h3) |-> (cnt_ff == 3'h7)) else $error("divide by eight fired early");

endmodule

/* File: sim/gst_ext_clk_model.sv */
// Purpose: External clock pin and timer crystal model.
// Assumes: Pulses are spaced in core clock cycles, phase offset 7 ns.
// Notes: Both lines stand low between bursts.
`timescale 1ns/1ns
module gst_ext_clk_model (
  input wire logic core_clk_in,
  input wire logic osc_en_in,
  input wire logic start_in,
  input wire logic [3:0] npulse_in,
  input wire logic [3:0] half_in,
  output logic ext_pin_out,
  output logic osc_clk_out,
  output logic busy_out
);
  initial begin
    ext_pin_out = 1'b0;
    osc_clk_out = 1'b0;
    busy_out = 1'b0;
  end

  // ====================
  // Burst of rising edges on the pin, or on the crystal while it is powered
  always @(posedge start_in) begin
    busy_out = 1'b1;
    repeat (npulse_in) begin
      repeat (half_in) @(posedge core_clk_in);
      #7;
      if (osc_en_in) begin
        osc_clk_out = 1'b1;
      end else begin
        ext_pin_out = 1'b1;
      end
      repeat (half_in) @(posedge core_clk_in);
      #7;
      osc_clk_out = 1'b0;
      ext_pin_out = 1'b0;
    end
    busy_out = 1'b0;
  end
endmodule

/* File: sim/testbench.sv */
// Purpose: Self-checking bench for the gated timer.
// Assumes: AHB-Lite single word transfers, one slave.
// Notes: Counts from timed runs are checked within a small tolerance.
`timescale 1ns/1ns
module testbench import gst_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hwrite = 1'b0;
  logic sevt = 1'b0;
  logic dev_osc = 1'b0;
  logic start = 1'b0;
  logic [15:0] haddr = 16'h0000;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [3:0] gsrc = 4'h0;
  logic [3:0] npulse = 4'h1;
  logic [3:0] half = 4'h8;
  logic hready, hresp, osc_en, gval, irq, pin, osc, busy;
  logic [31:0] hrdata, rd;
  logic [15:0] c0, c1;
  logic [7:0] v;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  logic [11:0] regs [7] = '{GST_IDX_CONTROL, GST_IDX_COUNT_LO, GST_IDX_COUNT_HI, GST_IDX_GATE,
    GST_IDX_IRQ_ST, GST_IDX_IRQ_MASK, 12'h000};

  gst_timer i_gst_timer (.core_clk_in(clk), .rst_n_in(rst_n), .hsel_in(1'b1), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata), .external_clock_pin_in(pin),
    .timer_osc_clk_in(osc), .device_clock_from_timer_osc_in(dev_osc), .gate_src_in(gsrc),
    .sevt_in(sevt), .oscillator_enable_out(osc_en), .gate_value_out(gval), .irq_out(irq));

  gst_ext_clk_model i_gst_ext_clk_model (.core_clk_in(clk), .osc_en_in(osc_en), .start_in(start),
    .npulse_in(npulse), .half_in(half), .ext_pin_out(pin), .osc_clk_out(osc), .busy_out(busy));

  always #20 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      final_report();
    end
  end

  // ====================
  // Checking and bus tasks
  function automatic int exp_cnt(input int src, input int psc, input int cycles);
    return (src == 0 ? cycles / 4 : cycles) >> psc;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic near(input logic [15:0] got, input int exp, input int tol);
    chk({31'h0, (^got !== 1'bx) && (int'(got) >= exp - tol) && (int'(got) <= exp + tol)}, 32'h1);
  endtask

  // Waits for the edge at which hready is high, capturing read data there
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    do begin
      @(negedge clk);
      r = hready;
      d = hrdata;
      @(posedge clk);
    end while (r !== 1'b1);
  endtask

  task automatic xfer(input logic [11:0] idx, input logic wr, input logic [7:0] wd, output logic [31:0] d);
    haddr <= {2'b00, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy(d);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy(d);
  endtask

  task automatic bw(input logic [11:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    xfer(idx, 1'b1, wd, d);
  endtask

  task automatic br(input logic [11:0] idx);
    xfer(idx, 1'b0, 8'h00, rd);
  endtask

  task automatic set_cnt(input logic [15:0] c);
    bw(GST_IDX_COUNT_HI, c[15:8]);
    bw(GST_IDX_COUNT_LO, c[7:0]);
  endtask

  task automatic get_cnt(output logic [15:0] c);
    br(GST_IDX_COUNT_HI);
    c[15:8] = rd[7:0];
    br(GST_IDX_COUNT_LO);
    c[7:0] = rd[7:0];
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ====================
  // Main sequence
  initial begin
    void'($urandom(32'hfeaa_0352));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (regs[i]) begin
      br(regs[i]);
      // Gate value reads one: active-low gate with its input low
      chk(rd, (regs[i] == GST_IDX_GATE) ? 32'h4 : 32'h0);
      chk(hresp, 1'b0);
    end
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom) & 8'hfe;
      bw(GST_IDX_CONTROL, v);
      br(GST_IDX_CONTROL);
      chk(rd, {24'h0, v});
      chk(osc_en, v[3]);
    end
    $display("test control access done");
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 4; p++) begin
        n = 200 + $urandom % 200;
        v = {s[1:0], p[1:0], 1'b0, 1'($urandom), 2'b01};
        bw(GST_IDX_CONTROL, 8'h00);
        set_cnt(16'h0000);
        bw(GST_IDX_CONTROL, v);
        repeat (n) @(posedge clk);
        bw(GST_IDX_CONTROL, v & 8'hfe);
        get_cnt(c0);
        near(c0, exp_cnt(s, p, n + 2), 2);
        repeat (30) @(posedge clk);
        get_cnt(c1);
        chk(c1, c0);
      end
    end
    $display("test rates done");
    bw(GST_IDX_CONTROL, 8'h02);
    bw(GST_IDX_COUNT_HI, 8'h34);
    bw(GST_IDX_COUNT_LO, 8'h56);
    bw(GST_IDX_CONTROL, 8'h00);
    get_cnt(c0);
    chk(c0, 16'h3456);
    bw(GST_IDX_CONTROL, 8'h02);
    br(GST_IDX_COUNT_LO);
    bw(GST_IDX_CONTROL, 8'h00);
    bw(GST_IDX_COUNT_HI, 8'h99);
    bw(GST_IDX_CONTROL, 8'h02);
    br(GST_IDX_COUNT_HI);
    chk(rd, 32'h34);
    bw(GST_IDX_CONTROL, 8'h00);
    br(GST_IDX_COUNT_HI);
    chk(rd, 32'h99);
    $display("test wide access done");
    set_cnt(16'hfff0);
    bw(GST_IDX_CONTROL, 8'h41);
    repeat (40) @(posedge clk);
    bw(GST_IDX_CONTROL, 8'h00);
    br(GST_IDX_IRQ_ST);
    chk(rd & 32'h1, 32'h1);
    chk(irq, 1'b0);
    bw(GST_IDX_IRQ_MASK, 8'h01);
    @(negedge clk);
    chk(irq, 1'b1);
    @(posedge clk);
    bw(GST_IDX_IRQ_ST, 8'h01);
    @(negedge clk);
    chk(irq, 1'b0);
    @(posedge clk);
    $display("test overflow done");
    // The instruction clock serves the trigger run, not the system clock
    set_cnt(16'h1234);
    bw(GST_IDX_CONTROL, 8'h01);
    repeat (10) @(posedge clk);
    sevt <= 1'b1;
    @(posedge clk);
    sevt <= 1'b0;
    bw(GST_IDX_CONTROL, 8'h00);
    get_cnt(c0);
    near(c0, 1, 1);
    $display("test trigger done");
    for (int k = 0; k < 3; k++) begin
      v = (k == 2) ? 8'h8d : {5'b1_0000, k[0], 2'b01};
      set_cnt(16'h0000);
      bw(GST_IDX_CONTROL, v);
      npulse <= 4'(1 + $urandom % 8);
      half <= 4'(6 + $urandom % 4);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      do @(posedge clk); while (busy !== 1'b0);
      repeat (10) @(posedge clk);
      bw(GST_IDX_CONTROL, v & 8'hfe);
      get_cnt(c0);
      chk(c0, {12'h0, npulse});
    end
    $display("test external done");
    set_cnt(16'h0000);
    bw(GST_IDX_GATE, 8'hc0);
    bw(GST_IDX_CONTROL, 8'h41);
    repeat (30) @(posedge clk);
    gsrc <= 4'h1;
    repeat (40) @(posedge clk);
    @(negedge clk);
    chk(gval, 1'b1);
    @(posedge clk);
    gsrc <= 4'h0;
    repeat (10) @(posedge clk);
    bw(GST_IDX_CONTROL, 8'h00);
    get_cnt(c0);
    near(c0, 40, 4);
    set_cnt(16'h0000);
    bw(GST_IDX_GATE, 8'hd8);
    br(GST_IDX_GATE);
    chk(rd & 32'hfb, 32'hd8);
    bw(GST_IDX_CONTROL, 8'h41);
    for (int w = 0; w < 2; w++) begin
      repeat (10) @(posedge clk);
      gsrc <= 4'h1;
      repeat (20) @(posedge clk);
      gsrc <= 4'h0;
      repeat (10) @(posedge clk);
      get_cnt(c1);
      if (w == 0) begin
        c0 = c1;
        near(c0, 20, 4);
      end
    end
    chk(c1, c0);
    br(GST_IDX_GATE);
    chk(rd[3], 1'b0);
    br(GST_IDX_IRQ_ST);
    chk(rd[1], 1'b1);
    // Toggle mode on gate source one: each rising gate edge flips the window
    bw(GST_IDX_GATE, 8'he1);
    for (int w = 0; w < 2; w++) begin
      gsrc <= 4'h2;
      repeat (6) @(posedge clk);
      gsrc <= 4'h0;
      repeat (6) @(posedge clk);
      chk(gval, w == 0);
    end
    $display("test gate done");
    dev_osc <= 1'b1;
    repeat (4) @(posedge clk);
    br(GST_IDX_CLKCTL);
    chk(rd, 32'h10);
    $display("test clock status done");
    final_report();
  end
endmodule
